// ---- gpio_wake_pkg.sv ----
// Package: register map, field layout, reset values, timing and carriers of the GPIO block
package gpio_wake_pkg;

   // =====================================================================
   // Register indices and byte addresses (index * 4)
   // =====================================================================
   localparam logic [7:0] IDX_E_DIR   = 8'h01;
   localparam logic [7:0] IDX_A_DIR   = 8'h02;
   localparam logic [7:0] IDX_A_VAL   = 8'h03;
   localparam logic [7:0] IDX_B_DIR   = 8'h05;
   localparam logic [7:0] IDX_B_VAL   = 8'h06;
   localparam logic [7:0] IDX_D_DIR   = 8'h0c;
   localparam logic [7:0] IDX_D_VAL   = 8'h0d;
   localparam logic [7:0] IDX_E_VAL   = 8'h0e;
   localparam logic [7:0] IDX_CTRL    = 8'h11;
   localparam logic [7:0] IDX_HALT    = 8'h20;
   localparam logic [7:0] IDX_IRQ_ST  = 8'h21;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h22;

   // Byte address of a register index
   function automatic logic [11:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'h0, idx, 2'h0};
   endfunction

   // =====================================================================
   // Field positions and reset values
   // =====================================================================
   localparam int         CTRL_FMT_BIT    = 1;
   localparam int         CTRL_HYST_BIT   = 2;
   localparam int         IRQ_WAKE_BIT    = 0;
   localparam int         IRQ_RESET_BIT   = 1;
   localparam int         CARRIER_BIT     = 3;
   localparam logic [3:0] DIR_RESET       = 4'h0;
   localparam logic [3:0] CTRL_RESET      = 4'h0;
   localparam logic [1:0] IRQ_RESET       = 2'h0;
   localparam logic [11:0] WAKE_VECTOR    = 12'h004;

   // =====================================================================
   // Timing: 38 kHz carrier from a 200 MHz clock
   // =====================================================================
   localparam int         CLK_HZ          = 200_000_000;
   localparam int         CARRIER_HZ      = 38_000;
   localparam int         HALF_CYC_INT    = CLK_HZ / (2 * CARRIER_HZ);
   localparam logic [11:0] CARRIER_HALF   = 12'(HALF_CYC_INT);

   // =====================================================================
   // Carriers
   // =====================================================================
   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_HALT = 1'b1
   } run_state_t;

   // One 4-bit port: direction and value latch
   typedef struct packed {
      logic [3:0] dir;
      logic [3:0] val;
   } port_regs_t;

   // Static option straps
   typedef struct packed {
      logic [15:0] wake_enable;      // {E,D,B,A}
      logic [15:0] strong_pulldown;
      logic [15:0] weak_pulldown;
      logic        both_edge_wake_option;
      logic        ir_carrier_option;
      logic        external_reset_pin_option;
   } options_t;

   // Pin pad controls, 16 pins ordered {E,D,B,A}
   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
      logic [15:0] strong_pd_en;
      logic [15:0] weak_pd_en;
      logic [15:0] pullup_en;
      logic        hysteresis_input_select;
   } pad_ctrl_t;
endpackage

// ---- quad_nibble_gpio_wakeup.sv ----
// Four 4-bit GPIO ports with halt wake-up, IR carrier and APB register access
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module quad_nibble_gpio_wakeup
   import gpio_wake_pkg::*;
(
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   // APB slave
   input  wire logic                     i_psel,
   input  wire logic                     i_penable,
   input  wire logic                     i_pwrite,
   input  wire logic [11:0]              i_paddr,
   input  wire logic [31:0]              i_pwdata,
   output logic      [31:0]              o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   // Static option straps
   input  wire gpio_wake_pkg::options_t  i_options,
   // Core halt request, one-cycle pulse
   input  wire logic                     i_halt_req,
   // Pins {E,D,B,A}
   input  wire logic [15:0]              i_pin,
   output gpio_wake_pkg::pad_ctrl_t      o_pad,
   // System side
   output logic                          o_halted,
   output logic                          o_wake_pulse,
   output logic      [11:0]              o_wake_vector,
   output logic                          o_ext_reset,
   output logic                          o_audio_twos_complement_select,
   output logic                          o_irq
);
   import gpio_wake_pkg::*;

   // ======================================================================
   // State
   // ======================================================================
   typedef struct packed {
      port_regs_t [3:0] port;        // 0=A 1=B 2=D 3=E
      logic [3:0]       ctrl;
      logic [15:0]      sync1;
      logic [15:0]      sync2;
      logic [15:0]      snapshot;
      run_state_t       state;
      logic             wake;
      logic [11:0]      div_cnt;
      logic             carrier;
      logic [1:0]       irq_status;
      logic [1:0]       irq_mask;
      logic [31:0]      rdata;
   } state_t;

   state_t      cur;
   state_t      next_cur;
   logic [15:0] dir_all;
   logic [15:0] val_all;
   logic [15:0] rd_all;
   logic [15:0] edges;
   logic        wake_hit;
   logic        rst_pin_low;
   logic        access;
   logic        wr;
   logic [1:0]  irq_set;

   // ======================================================================
   // Programming notes
   // ======================================================================
   // Byte addresses, index times four:
   //   0x004 E dir, 0x038 E value
   //   0x008 A dir, 0x00c A value
   //   0x014 B dir, 0x018 B value
   //   0x030 D dir, 0x034 D value
   //   0x044 control: bit2 hysteresis
   //   0x044 control: bit1 audio format
   //   0x080 halt status, bit0, read only
   //   0x084 event status, write one clears
   //   0x088 event mask, same layout
   // Data in low bits; upper bits read zero
   // Unmapped: reads zero, writes ignored

   // Bus timing
   // No wait states; pready stays high
   // Read data taken at the setup edge
   // Writes land at the access edge
   // Back-to-back transfers are fine

   // Value reads
   // Output bits return the latch
   // Input bits return the pin
   // Pin seen two clocks late

   // Event status
   // bit0: wake-up from halt
   // bit1: reset pin seen low
   // Set beats a clear in one cycle,
   // so no event is lost to a clear
   // Interrupt level: status and mask

   // Halt and wake-up
   // Halt request pulse: halt next cycle
   // Synchronised pins saved at entry
   // Enabled pin rising since entry wakes
   // Both-edge strap: any change wakes
   // Pin high at entry cannot wake
   // when only rising edges count
   // Three clocks from pin edge to wake
   // Wake pulse lasts one clock
   // Halt request in halt is ignored

   // Port A bit3
   // Carrier strap gates latch by carrier
   // Divider runs free: first burst may
   // start mid-period, traded for area
   // Halt forces it low for the emitter
   // Direction is kept in halt

   // Port B bit3
   // Reset strap: pad released, pull-up,
   // no pull-downs
   // Low after sync asserts reset
   // Value register reads the pin only if B3 dir is 0

   // Pull-downs
   // Follow straps on input pins only, except B3 under the reset strap
   // Output pins never pull down

   // Straps
   // Must be stable before reset ends
   // Nothing here resamples them
   // Value latches are not reset:
   // unwritten outputs are unknown,
   // but all pins start as inputs

   // Clocking
   // One clock; carrier is a divided toggle
   // Block keeps running in halt
   // Pins pass two flops before use

   // Hazards
   // Pin edge right at halt entry may
   // fall before the snapshot and be lost
   // Strap change after reset unsupported
   // Reset strap overrides B3 direction
   // Mask write does not clear status

   // Limits
   // Carrier half period rounds down,
   // so the rate is a touch high
   // Wake vector is a constant
   // Audio format bit is only exported
   // Hysteresis bit is only exported

   // Reset
   // Synchronous, active low
   // Two clocks let synchronisers fill
   // Halt, events, mask, read data clear

   // ======================================================================
   // Flattened views and pad controls
   // ======================================================================
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         dir_all[p*4 +: 4] = cur.port[p].dir;
         val_all[p*4 +: 4] = cur.port[p].val;
      end
   end

   // Read view: latch for outputs, synchronised pin for inputs
   assign rd_all = (dir_all & val_all) | (~dir_all & cur.sync2);

   // Pad drive; bit 7 (port B bit3) is released when it serves as reset input
   always_comb begin
      o_pad.oe  = dir_all;
      o_pad.out = val_all;
      if (i_options.ir_carrier_option) begin
         o_pad.out[CARRIER_BIT] = val_all[CARRIER_BIT] & cur.carrier;
      end                                                       // else plain latch
      if (cur.state == ST_HALT) begin
         o_pad.out[CARRIER_BIT] = 1'b0;
      end
      if (i_options.external_reset_pin_option) begin
         o_pad.oe[7]  = 1'b0;
         o_pad.out[7] = 1'b0;
      end
      o_pad.strong_pd_en = ~dir_all & i_options.strong_pulldown;
      o_pad.weak_pd_en   = ~dir_all & i_options.weak_pulldown;
      o_pad.pullup_en    = 16'h0000;
      o_pad.pullup_en[7] = i_options.external_reset_pin_option;
      if (i_options.external_reset_pin_option) begin
         o_pad.strong_pd_en[7] = 1'b0;
         o_pad.weak_pd_en[7]   = 1'b0;
      end
      o_pad.hysteresis_input_select = cur.ctrl[CTRL_HYST_BIT];
   end

   // ======================================================================
   // Wake detection against the halt-entry snapshot
   // ======================================================================
   // Comparing with the snapshot rather than last cycle keeps an edge that
   // happened while the core clock was stopped.
   always_comb begin
      if (i_options.both_edge_wake_option) begin
         edges = cur.sync2 ^ cur.snapshot;
      end else begin
         edges = cur.sync2 & ~cur.snapshot;
      end
   end
   assign wake_hit = |(edges & i_options.wake_enable);

   // External reset pin, active low, after synchronisation
   assign rst_pin_low = i_options.external_reset_pin_option & ~cur.sync2[7];

   // APB decode helpers
   assign access = i_psel & i_penable;
   assign wr     = access & i_pwrite;

   // ======================================================================
   // Next-state logic
   // ======================================================================
   always_comb begin
      next_cur       = cur;
      irq_set        = 2'h0;
      next_cur.sync1 = i_pin;
      next_cur.sync2 = cur.sync1;
      next_cur.wake  = 1'b0;

      // Carrier divider, free running; a toggle every half period
      if (cur.div_cnt >= CARRIER_HALF - 12'h001) begin
         next_cur.div_cnt = 12'h000;
         next_cur.carrier = ~cur.carrier;
      end else begin
         next_cur.div_cnt = cur.div_cnt + 12'h001;
      end

      // Halt entry and wake-up
      case (cur.state)
         ST_RUN: begin
            if (i_halt_req) begin
               next_cur.state    = ST_HALT;
               next_cur.snapshot = cur.sync2;
            end
         end
         ST_HALT: begin
            if (wake_hit) begin
               next_cur.state = ST_RUN;
               next_cur.wake  = 1'b1;
               irq_set[IRQ_WAKE_BIT] = 1'b1;
            end
         end
         default: next_cur.state = ST_RUN;
      endcase
      irq_set[IRQ_RESET_BIT] = rst_pin_low;

      // Register writes at the access phase
      if (wr) begin
         if (i_paddr == byte_addr(IDX_A_DIR)) begin
            next_cur.port[0].dir = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_A_VAL)) begin
            next_cur.port[0].val = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_B_DIR)) begin
            next_cur.port[1].dir = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_B_VAL)) begin
            next_cur.port[1].val = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_D_DIR)) begin
            next_cur.port[2].dir = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_D_VAL)) begin
            next_cur.port[2].val = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_E_DIR)) begin
            next_cur.port[3].dir = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_E_VAL)) begin
            next_cur.port[3].val = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_CTRL)) begin
            next_cur.ctrl = i_pwdata[3:0];
         end else if (i_paddr == byte_addr(IDX_IRQ_ST)) begin
            next_cur.irq_status = cur.irq_status & ~i_pwdata[1:0];
         end else if (i_paddr == byte_addr(IDX_IRQ_MSK)) begin
            next_cur.irq_mask = i_pwdata[1:0];
         end
      end
      // Set wins over a write-one clear in the same cycle
      next_cur.irq_status = next_cur.irq_status | irq_set;

      // Read data captured on the setup cycle so it is registered at access
      next_cur.rdata = 32'h0000_0000;
      if (i_psel && !i_pwrite) begin
         if (i_paddr == byte_addr(IDX_A_DIR)) begin
            next_cur.rdata[3:0] = cur.port[0].dir;
         end else if (i_paddr == byte_addr(IDX_A_VAL)) begin
            next_cur.rdata[3:0] = rd_all[3:0];
         end else if (i_paddr == byte_addr(IDX_B_DIR)) begin
            next_cur.rdata[3:0] = cur.port[1].dir;
         end else if (i_paddr == byte_addr(IDX_B_VAL)) begin
            next_cur.rdata[3:0] = rd_all[7:4];
         end else if (i_paddr == byte_addr(IDX_D_DIR)) begin
            next_cur.rdata[3:0] = cur.port[2].dir;
         end else if (i_paddr == byte_addr(IDX_D_VAL)) begin
            next_cur.rdata[3:0] = rd_all[11:8];
         end else if (i_paddr == byte_addr(IDX_E_DIR)) begin
            next_cur.rdata[3:0] = cur.port[3].dir;
         end else if (i_paddr == byte_addr(IDX_E_VAL)) begin
            next_cur.rdata[3:0] = rd_all[15:12];
         end else if (i_paddr == byte_addr(IDX_CTRL)) begin
            next_cur.rdata[3:0] = cur.ctrl;
         end else if (i_paddr == byte_addr(IDX_HALT)) begin
            next_cur.rdata[0] = (cur.state == ST_HALT);
         end else if (i_paddr == byte_addr(IDX_IRQ_ST)) begin
            next_cur.rdata[1:0] = cur.irq_status;
         end else if (i_paddr == byte_addr(IDX_IRQ_MSK)) begin
            next_cur.rdata[1:0] = cur.irq_mask;
         end
      end
   end

   // ======================================================================
   // State register
   // ======================================================================
   // Value latches keep their contents through reset; directions, control, halt, events, mask and read data reset.
   always_ff @(posedge i_clk) begin
      cur <= next_cur;
      if (!i_rst_n) begin
         for (int p = 0; p < 4; p++) begin
            cur.port[p].dir <= DIR_RESET;
         end
         cur.ctrl       <= CTRL_RESET;
         cur.state      <= ST_RUN;
         cur.wake       <= 1'b0;
         cur.div_cnt    <= 12'h000;
         cur.carrier    <= 1'b0;
         cur.irq_status <= IRQ_RESET;
         cur.irq_mask   <= IRQ_RESET;
         cur.rdata      <= 32'h0000_0000;
         cur.snapshot   <= 16'h0000;
      end
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   // Zero wait states; unmapped addresses read zero without error
   assign o_prdata     = cur.rdata;
   assign o_pready     = 1'b1;
   assign o_pslverr    = 1'b0;
   assign o_halted     = (cur.state == ST_HALT);
   assign o_wake_pulse = cur.wake;
   assign o_wake_vector = WAKE_VECTOR;
   assign o_ext_reset  = rst_pin_low;
   assign o_audio_twos_complement_select = cur.ctrl[CTRL_FMT_BIT];
   assign o_irq        = |(cur.irq_status & cur.irq_mask);
endmodule

// ---- gpio_board_model.sv ----
// Board model: external drivers and pulls on the sixteen GPIO pins
`timescale 1ns/10ps
module gpio_board_model
   import gpio_wake_pkg::*;
(
   // Clock
   input  wire logic                    i_clk,
   // Pad controls from the block
   input  wire gpio_wake_pkg::pad_ctrl_t i_pad,
   // Board drivers
   input  wire logic [15:0]             i_drv_en,
   input  wire logic [15:0]             i_drv_val,
   // Resolved pin levels
   output logic      [15:0]             o_pin
);
   logic flip = 1'b0;

   // ==========
   // Wire resolution
   // Floating pins wander each cycle so a stale level never reads as valid
   always @(posedge i_clk) flip <= ~flip;
   // Pad drive wins, then the board, then pulls, else floating
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (i_pad.oe[i])
            o_pin[i] = i_pad.out[i];
         else if (i_drv_en[i])
            o_pin[i] = i_drv_val[i];
         else if (i_pad.pullup_en[i])
            o_pin[i] = 1'b1;
         else if (i_pad.strong_pd_en[i] | i_pad.weak_pd_en[i])
            o_pin[i] = 1'b0;
         else
            o_pin[i] = flip ^ i[0];
      end
   end
endmodule

// ---- quad_nibble_gpio_wakeup_chk.sv ----
// Checker: concurrent properties on the GPIO wake-up block ports
`timescale 1ns/10ps
module quad_nibble_gpio_wakeup_chk
   import gpio_wake_pkg::*;
(
   // Clock and reset
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   // Watched ports
   input  wire gpio_wake_pkg::options_t  i_options,
   input  wire logic                     i_halt_req,
   input  wire logic [15:0]              i_pin,
   input  wire gpio_wake_pkg::pad_ctrl_t o_pad,
   input  wire logic                     o_halted,
   input  wire logic                     o_wake_pulse,
   input  wire logic [11:0]              o_wake_vector,
   input  wire logic                     o_ext_reset
);
   logic [15:0] rst_mask;

   // ==========
   // Properties
   // Port B bit3 loses its pull-downs when it serves as reset input
   assign rst_mask = {8'h00, i_options.external_reset_pin_option, 7'h00};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   reset_dir_a: assert property ($rose(i_rst_n) |-> o_pad.oe == 16'h0000)
      else $error("pins not inputs after reset");
   pd_out_off_a: assert property ((o_pad.oe & (o_pad.strong_pd_en | o_pad.weak_pd_en)) == 16'h0000)
      else $error("pull-down on an output pin");
   pd_strap_a: assert property (o_pad.strong_pd_en == (i_options.strong_pulldown & ~o_pad.oe & ~rst_mask)
      && o_pad.weak_pd_en == (i_options.weak_pulldown & ~o_pad.oe & ~rst_mask)) else $error("pull-down mismatch");
   halt_enter_a: assert property (i_halt_req && !o_halted |=> o_halted)
      else $error("halt not entered");
   halt_ir_low_a: assert property (o_halted |-> !o_pad.out[3])
      else $error("port A bit3 high in halt");
   wake_exit_a: assert property (o_wake_pulse |-> $past(o_halted) && !o_halted && o_wake_vector == 12'h004)
      else $error("wake pulse bad");
   wake_fall_a: assert property ($fell(o_halted) |-> o_wake_pulse ##1 !o_wake_pulse)
      else $error("halt left without one wake pulse");
   rst_pin_pull_a: assert property (i_options.external_reset_pin_option |-> o_pad.pullup_en[7] && !o_pad.oe[7])
      else $error("reset pin pad wrong");
   rst_pin_low_a: assert property ((i_options.external_reset_pin_option && !i_pin[7]) [*3] |-> o_ext_reset)
      else $error("reset pin low not seen");
   gpio_b3_a: assert property (!i_options.external_reset_pin_option |-> !o_ext_reset && !o_pad.pullup_en[7])
      else $error("port B bit3 not plain");
   halt_c: cover property (i_halt_req && !o_halted);
   wake_c: cover property (o_wake_pulse);
   ext_rst_c: cover property (o_ext_reset);
endmodule
bind quad_nibble_gpio_wakeup quad_nibble_gpio_wakeup_chk i_chk (.i_clk, .i_rst_n, .i_options, .i_halt_req,
   .i_pin, .o_pad, .o_halted, .o_wake_pulse, .o_wake_vector, .o_ext_reset);

// ---- tb_quad_nibble_gpio_wakeup.sv ----
// Testbench: registers, pins, wake-up, carrier and reset pin of the GPIO block
`timescale 1ns/10ps
module tb_quad_nibble_gpio_wakeup;
   import gpio_wake_pkg::*;
   // ==========
   // Signals
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_halt_req = 1'b0;
   logic o_pready, o_pslverr, o_halted, o_wake_pulse, o_ext_reset, o_audio_twos_complement_select, o_irq;
   logic [11:0] i_paddr = 12'h000, o_wake_vector;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [15:0] i_pin, drv_en = 16'h0, drv_val = 16'h0;
   logic [11:0] dir_a [4] = '{12'h008, 12'h014, 12'h030, 12'h004};
   logic [11:0] val_a [4] = '{12'h00c, 12'h018, 12'h034, 12'h038};
   options_t    i_options = '0;
   pad_ctrl_t   o_pad;
   int          n_fail = 0, compares = 0;

   always #2.5 i_clk = ~i_clk;
   quad_nibble_gpio_wakeup i_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_options, .i_halt_req, .i_pin, .o_pad, .o_halted, .o_wake_pulse,
      .o_wake_vector, .o_ext_reset, .o_audio_twos_complement_select, .o_irq);
   gpio_board_model i_board (.i_clk, .i_pad(o_pad), .i_drv_en(drv_en), .i_drv_val(drv_val), .o_pin(i_pin));

   // ==========
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_paddr <= a;
      i_pwrite <= w;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(32'h1, 32'h0, "bus timeout");
         wrap_up();
      end
      rd = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Straps change only while reset is held
   task automatic do_reset(input logic [15:0] wk, input logic both, input logic car, input logic rp);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      i_options <= '{wake_enable: wk, strong_pulldown: 16'h3333, weak_pulldown: 16'h0f0f,
                     both_edge_wake_option: both, ir_carrier_option: car, external_reset_pin_option: rp};
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
   endtask
   task automatic wait_wake;
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wake_pulse !== 1'b1 && n < 8);
   endtask

   // ==========
   // Scenarios
   task automatic t_regs;
      for (int p = 0; p < 4; p++) begin
         apb(dir_a[p], 1'b0, 32'h0);
         chk(rd, 32'h0, "direction reset");
      end
      apb(12'h044, 1'b0, 32'h0);
      chk(rd, 32'h0, "control reset");
      apb(12'h0fc, 1'b1, 32'hf);
      chk(o_pslverr, 32'h0, "no slave error");
      apb(12'h0fc, 1'b0, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      chk(o_pad.oe, 32'h0, "inputs after reset");
   endtask
   // Bits 1,3 out with latch 0xe; input bits 0,2 see board value 0x9
   task automatic t_ports;
      for (int p = 0; p < 4; p++) begin
         drv_en[p*4+:4] <= 4'h5;
         drv_val[p*4+:4] <= 4'h9;
         apb(dir_a[p], 1'b1, 32'ha);
         apb(val_a[p], 1'b1, 32'he);
         apb(val_a[p], 1'b0, 32'h0);
         chk(rd, 32'hb, "port read");
         chk(o_pad.oe[p*4+:4], 32'ha, "direction");
         chk(o_pad.out[p*4+:4] & 4'ha, 32'ha, "drive");
         chk(o_pad.strong_pd_en[p*4+:4], 32'h1, "strong pull");
         chk(o_pad.weak_pd_en[p*4+:4], p[0] ? 32'h0 : 32'h5, "weak pull");
      end
      chk(o_ext_reset, 32'h0, "B3 plain output");
   endtask
   task automatic t_ctrl;
      for (int v = 0; v < 4; v++) begin
         apb(12'h044, 1'b1, {28'h0, 1'b0, v[1], v[0], 1'b0});
         apb(12'h044, 1'b0, 32'h0);
         chk(rd, {28'h0, 1'b0, v[1], v[0], 1'b0}, "control read");
         chk(o_pad.hysteresis_input_select, v[1], "hysteresis");
         chk(o_audio_twos_complement_select, v[0], "audio format");
      end
   endtask
   // A0 starts high and falls; A1 rises but is not wake-enabled
   task automatic t_wake(input logic both);
      do_reset(16'h0011, both, 1'b0, 1'b0);
      drv_en <= 16'h00f7;
      drv_val <= 16'h0001;
      apb(dir_a[0], 1'b1, 32'h8);
      apb(val_a[0], 1'b1, 32'h8);
      apb(12'h088, 1'b1, 32'h1);
      chk(o_pad.out[3], 32'h1, "A3 plain high");
      @(posedge i_clk);
      i_halt_req <= 1'b1;
      @(posedge i_clk);
      i_halt_req <= 1'b0;
      @(posedge i_clk);
      chk(o_halted, 32'h1, "halted");
      chk(o_pad.out[3], 32'h0, "A3 low in halt");
      apb(12'h080, 1'b0, 32'h0);
      chk(rd, 32'h1, "halt status read");
      drv_val[1] <= 1'b1;
      wait_wake();
      chk(o_halted, 32'h1, "disabled pin woke");
      drv_val[0] <= 1'b0;
      wait_wake();
      chk(o_wake_pulse, both, "falling edge");
      if (!both) begin
         drv_val[4] <= 1'b1;
         wait_wake();
         chk(o_wake_pulse, 32'h1, "rising edge");
      end
      chk(o_wake_vector, 32'h004, "wake vector");
      repeat (2) @(posedge i_clk);
      chk(o_irq, 32'h1, "irq raised");
      apb(12'h088, 1'b1, 32'h0);
      @(posedge i_clk);
      chk(o_irq, 32'h0, "irq masked");
      apb(12'h084, 1'b1, 32'h1);
      apb(12'h084, 1'b0, 32'h0);
      chk(rd[0], 32'h0, "status cleared");
   endtask
   task automatic t_carrier;
      int n;
      logic l;
      do_reset(16'h0, 1'b0, 1'b1, 1'b0);
      apb(dir_a[0], 1'b1, 32'h8);
      apb(val_a[0], 1'b1, 32'h8);
      for (int k = 0; k < 2; k++) begin
         l = o_pad.out[3];
         n = 0;
         do begin
            @(posedge i_clk);
            n++;
         end while (o_pad.out[3] === l && n < 3000);
      end
      chk(n, 200_000_000 / (2 * 38_000), "carrier half period");
      apb(val_a[0], 1'b1, 32'h0);
      l = 1'b0;
      repeat (2700) begin
         @(posedge i_clk);
         l = l | (o_pad.out[3] !== 1'b0);
      end
      chk(l, 32'h0, "carrier off drives low");
   endtask
   task automatic t_rstpin;
      drv_en <= 16'h0;
      do_reset(16'h0, 1'b0, 1'b0, 1'b1);
      apb(dir_a[1], 1'b1, 32'hf);
      chk(o_pad.oe[7], 32'h0, "reset pin not driven");
      chk(o_pad.pullup_en[7], 32'h1, "reset pin pull-up");
      drv_en[7] <= 1'b1;
      drv_val[7] <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(o_ext_reset, 32'h1, "reset asserted");
      drv_en[7] <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(o_ext_reset, 32'h0, "reset released");
   endtask

   // ==========
   // Main sequence
   initial begin
      do_reset(16'h0, 1'b0, 1'b0, 1'b0);
      t_regs();
      t_ports();
      t_ctrl();
      t_wake(1'b0);
      t_wake(1'b1);
      t_carrier();
      t_rstpin();
      wrap_up();
   end
endmodule
